/* pgrr_pkg.sv */
// package: constants and helpers for the peripheral gating, reset and ready block
package pgrr_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PERIPH = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_EN = 8'h00;
  localparam logic [7:0] ADDR_SLEEP_EN = 8'h04;
  localparam logic [7:0] ADDR_SOFT_RST = 8'h08;
  localparam logic [7:0] ADDR_GATING = 8'h0C;
  localparam logic [7:0] ADDR_READY = 8'h10;
  localparam logic [7:0] ADDR_RST_BUSY = 8'h14;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int GATING_BIT = 0;
  localparam logic [7:0] RUN_EN_RESET = 8'h00;
  localparam logic [7:0] SLEEP_EN_RESET = 8'hFF;
  localparam logic GATING_RESET = 1'b0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int READY_CYCLES = 5;
  localparam int RST_PULSE_NS = 200;
  localparam int RST_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] READY_CNT = 3'(READY_CYCLES);
  localparam logic [2:0] RST_CNT = 3'(RST_CYCLES);

  // zero-extends a per-peripheral vector onto the data bus
  function automatic logic [DATA_W-1:0] pgrrPad(input logic [NUM_PERIPH-1:0] v);
    pgrrPad = {{(DATA_W-NUM_PERIPH){1'b0}}, v};
  endfunction

endpackage

/* pgrr_slot_if.sv */
// interface: control and status of one peripheral slot
`timescale 1ns/1ns
interface pgrr_slot_if;
  logic runEn;
  logic sleepEn;
  logic gateOpt;
  logic cpuSleep;
  logic softRstReq;
  logic clkEn;
  logic rstOut;
  logic ready;

  modport ctrl (
    output runEn, sleepEn, gateOpt, cpuSleep, softRstReq,
    input clkEn, rstOut, ready
  );
  modport slot (
    input runEn, sleepEn, gateOpt, cpuSleep, softRstReq,
    output clkEn, rstOut, ready
  );
endinterface

/* pgrr_slot.sv */
// module: per-peripheral clock gate, reset pulse timer and ready timer
`timescale 1ns/1ns
module pgrr_slot (
  input wire logic ref_clk,
  input wire logic rst_n,
  pgrr_slot_if.slot slotBus
);
  import pgrr_pkg::*;

  logic [2:0] rstCnt_q;
  logic [2:0] rstCnt_d;
  logic [2:0] readyCnt_q;
  logic [2:0] readyCnt_d;
  logic rstOut_q;
  logic ready_q;
  logic clkEn_q;

  // reset pulse length, reloaded by each request
  always_comb begin
    if (slotBus.softRstReq) begin
      rstCnt_d = RST_CNT;
    end else if (rstCnt_q != 3'h0) begin
      rstCnt_d = rstCnt_q - 3'h1;
    end else begin
      rstCnt_d = rstCnt_q;
    end
  end

  // settle counter, cleared while off or in reset
  always_comb begin
    if (!slotBus.runEn || rstCnt_q != 3'h0 || slotBus.softRstReq) begin
      readyCnt_d = 3'h0;
    end else if (readyCnt_q != READY_CNT) begin
      readyCnt_d = readyCnt_q + 3'h1;
    end else begin
      readyCnt_d = readyCnt_q;
    end
  end

  // reset pulse and its output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstCnt_q <= 3'h0;
      rstOut_q <= 1'b0;
    end else begin
      rstCnt_q <= rstCnt_d;
      rstOut_q <= (rstCnt_d != 3'h0);
    end
  end

  // ready timer; untouched by sleep so state survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readyCnt_q <= 3'h0;
      ready_q <= 1'b0;
    end else begin
      readyCnt_q <= readyCnt_d;
      ready_q <= (readyCnt_d == READY_CNT);
    end
  end

  // clock enable: off in sleep only if gating option on and slot not kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkEn_q <= 1'b0;
    end else begin
      clkEn_q <= slotBus.runEn &&
        !(slotBus.cpuSleep && slotBus.gateOpt && !slotBus.sleepEn);
    end
  end

  assign slotBus.rstOut = rstOut_q;
  assign slotBus.ready = ready_q;
  assign slotBus.clkEn = clkEn_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence sStableOn;
    (slotBus.runEn && !rstOut_q && !slotBus.softRstReq)[*6];
  endsequence

  AST_NOT_READY_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !slotBus.runEn |=> !ready_q) else $error("ready while disabled");
  AST_NOT_READY_RST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rstOut_q |-> !ready_q) else $error("ready while in reset");
  AST_READY_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(slotBus.runEn) |-> (!ready_q)[*5]) else $error("ready too early");
  AST_READY_AFTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sStableOn |-> ready_q) else $error("ready not reached");
  AST_RST_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    slotBus.softRstReq |=> rstOut_q[*4]) else $error("reset pulse too short");
  AST_RST_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rstOut_q && !slotBus.softRstReq)[*4] |=> !rstOut_q) else $error("reset pulse stuck");
  AST_SLEEP_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    slotBus.cpuSleep && slotBus.gateOpt && !slotBus.sleepEn |=> !clkEn_q)
    else $error("clock not gated in sleep");
  AST_WAKE_CLK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    slotBus.runEn && !slotBus.cpuSleep |=> clkEn_q) else $error("clock not restored");
  AST_GATING_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    slotBus.runEn && !slotBus.gateOpt |=> clkEn_q) else $error("gated with option off");
  AST_READY_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ready_q && slotBus.runEn && !slotBus.softRstReq |=> ready_q)
    else $error("ready lost without cause");
endmodule

/* pgrr_top.sv */
// module: peripheral gating, reset and ready control with register port
// ---------------------------------------------------------------
// Summary of operation
// - a disabled peripheral or one held in reset reads as not ready
// - ready stays low while a peripheral settles after enable or reset release
// - a software reset drives the reset line for a fixed pulse, then drops it
// - a software reset touches only the targeted peripheral
// - with sleep enable clear and the global gating option set, the peripheral clock stops during sleep
// - on wake, clocks of run-enabled peripherals return by themselves
// - clock gating in sleep leaves peripheral state intact
// - with global gating off, sleep settings are kept but ignored
// - a peripheral is usable five cycles after its enabling write
// ---------------------------------------------------------------
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module pgrr_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [pgrr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pgrr_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [pgrr_pkg::DATA_W-1:0] regRdData,
  input wire logic cpuSleep,
  output logic [pgrr_pkg::NUM_PERIPH-1:0] periphClkEn,
  output logic [pgrr_pkg::NUM_PERIPH-1:0] periphRst,
  output logic [pgrr_pkg::NUM_PERIPH-1:0] periphReady
);
  import pgrr_pkg::*;

  logic [NUM_PERIPH-1:0] runEn_q;
  logic [NUM_PERIPH-1:0] sleepEn_q;
  logic gateOpt_q;
  logic [NUM_PERIPH-1:0] softRstPulse_q;
  logic [DATA_W-1:0] rdData_q;
  logic wrRun;
  logic wrSleep;
  logic wrSoftRst;
  logic wrGating;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  assign wrRun = regWrStb && (regAddr == ADDR_RUN_EN);
  assign wrSleep = regWrStb && (regAddr == ADDR_SLEEP_EN);
  assign wrSoftRst = regWrStb && (regAddr == ADDR_SOFT_RST);
  assign wrGating = regWrStb && (regAddr == ADDR_GATING);

  // run mode enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      runEn_q <= RUN_EN_RESET;
    end else if (wrRun) begin
      runEn_q <= regWrData[NUM_PERIPH-1:0];
    end
  end

  // sleep mode enables, kept whatever the gating option
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepEn_q <= SLEEP_EN_RESET;
    end else if (wrSleep) begin
      sleepEn_q <= regWrData[NUM_PERIPH-1:0];
    end
  end

  // global sleep gating option
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gateOpt_q <= GATING_RESET;
    end else if (wrGating) begin
      gateOpt_q <= regWrData[GATING_BIT];
    end
  end

  // write-one reset requests, one cycle per selected peripheral
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      softRstPulse_q <= '0;
    end else if (wrSoftRst) begin
      softRstPulse_q <= regWrData[NUM_PERIPH-1:0];
    end else begin
      softRstPulse_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // per-peripheral slots
  // ---------------------------------------------------------------
  pgrr_slot_if slotIf[NUM_PERIPH] ();

  for (genvar i = 0; i < NUM_PERIPH; i++) begin : gSlot
    assign slotIf[i].runEn = runEn_q[i];
    assign slotIf[i].sleepEn = sleepEn_q[i];
    assign slotIf[i].gateOpt = gateOpt_q;
    assign slotIf[i].cpuSleep = cpuSleep;
    assign slotIf[i].softRstReq = softRstPulse_q[i];
    assign periphClkEn[i] = slotIf[i].clkEn;
    assign periphRst[i] = slotIf[i].rstOut;
    assign periphReady[i] = slotIf[i].ready;

    pgrr_slot uSlot (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .slotBus(slotIf[i])
    );
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= '0;
    end else if (regRdStb) begin
      case (regAddr)
        ADDR_RUN_EN: begin
          rdData_q <= pgrrPad(runEn_q);
        end
        ADDR_SLEEP_EN: begin
          rdData_q <= pgrrPad(sleepEn_q);
        end
        ADDR_GATING: begin
          rdData_q <= pgrrPad({{(NUM_PERIPH-1){1'b0}}, gateOpt_q});
        end
        ADDR_READY: begin
          rdData_q <= pgrrPad(periphReady);
        end
        ADDR_RST_BUSY: begin
          rdData_q <= pgrrPad(periphRst);
        end
        default: begin
          rdData_q <= '0; // unmapped and write-only read zero
        end
      endcase
    end else begin
      rdData_q <= '0;
    end
  end

  assign regRdData = rdData_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence sEnableWrite0;
    wrRun && regWrData[0] && !runEn_q[0] && !periphRst[0] && softRstPulse_q[0] == 1'b0;
  endsequence

  AST_RST_TARGET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrSoftRst |-> ##2 ((periphRst & $past(regWrData[NUM_PERIPH-1:0], 2))
      == $past(regWrData[NUM_PERIPH-1:0], 2))) else $error("target not reset");
  AST_RST_ISOLATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (softRstPulse_q == '0) && (periphRst == '0) |=> periphRst == '0)
    else $error("reset without request");
  AST_READY_FIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sEnableWrite0 |-> ##1 (!periphReady[0])[*5]) else $error("usable before five cycles");
  AST_READY_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_READY |=> regRdData == pgrrPad($past(periphReady)))
    else $error("ready status mismatch");
  AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !regRdStb |=> regRdData == '0) else $error("read data outside slot");

  // clock enables follow run enables and the sleep gating terms
  AST_CLK_NEEDS_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periphClkEn & ~$past(runEn_q)) == '0) else $error("clock without run enable");
  AST_SLEEP_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuSleep && gateOpt_q |=> periphClkEn == $past(runEn_q & sleepEn_q))
    else $error("sleep mask not applied");
  AST_SLEEP_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuSleep && !gateOpt_q |=> periphClkEn == $past(runEn_q))
    else $error("sleep mask used with gating off");
  AST_WAKE_ALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(cpuSleep) |=> periphClkEn == $past(runEn_q))
    else $error("clocks not back after wake");
  AST_SLEEP_CFG_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wrSleep |=> sleepEn_q == $past(sleepEn_q)) else $error("sleep config lost");

  // ready never shows for a disabled or resetting peripheral
  AST_READY_NEEDS_RUN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periphReady & ~$past(runEn_q)) == '0) else $error("ready without run enable");
  AST_READY_NOT_RST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periphReady & periphRst) == '0) else $error("ready during reset");
  AST_SLEEP_READY_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpuSleep && !wrRun && (softRstPulse_q == '0) && (periphRst == '0)
      && (periphReady == runEn_q) |=> periphReady == $past(periphReady))
    else $error("ready disturbed by sleep");

  // soft reset: the request write, then the lines held and dropped by themselves
  sequence sSoftRstWrite;
    wrSoftRst && (regWrData[NUM_PERIPH-1:0] != '0);
  endsequence

  sequence sRstLinesHeld;
    (periphRst != '0)[*4];
  endsequence

  sequence sNoNewRequest;
    (!wrSoftRst)[*5];
  endsequence

  AST_RST_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sSoftRstWrite |-> ##2 sRstLinesHeld) else $error("reset lines not held");
  AST_RST_SELF_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sSoftRstWrite ##1 sNoNewRequest |=> periphRst == '0)
    else $error("reset lines not released");

  // soft reset leaves the stored enables and the gating option alone
  AST_RUN_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wrRun |=> runEn_q == $past(runEn_q)) else $error("run enables disturbed");
  AST_GATE_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wrGating |=> gateOpt_q == $past(gateOpt_q)) else $error("gating option disturbed");

  // read-back of stored configuration and live reset lines
  AST_RD_SLEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_SLEEP_EN |=> regRdData == pgrrPad($past(sleepEn_q)))
    else $error("sleep config read mismatch");
  AST_RD_GATING: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_GATING |=> regRdData == DATA_W'($past(gateOpt_q)))
    else $error("gating option read mismatch");
  AST_RD_RST_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_RST_BUSY |=> regRdData == pgrrPad($past(periphRst)))
    else $error("reset lines read mismatch");
  AST_RD_SOFT_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_SOFT_RST |=> regRdData == '0)
    else $error("request register not read as zero");
endmodule

/* pgrr_periph_model.sv */
// module: behavioural peripheral slots that count clocks and obey their reset lines
`timescale 1ns/1ns
module pgrr_periph_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [pgrr_pkg::NUM_PERIPH-1:0] periphClkEn,
  input wire logic [pgrr_pkg::NUM_PERIPH-1:0] periphRst,
  output logic [pgrr_pkg::NUM_PERIPH-1:0][15:0] activity
);
  import pgrr_pkg::*;
  // ---------------------------------------------------------------
  // per-slot state: advances only on a live clock, cleared by its own reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activity <= '0;
    end else begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        if (periphRst[i]) begin
          activity[i] <= 16'h0000;
        end else if (periphClkEn[i]) begin
          activity[i] <= activity[i] + 16'h0001;
        end
      end
    end
  end
endmodule

/* tb_pgrr_top.sv */
// testbench: register port stimulus, timed output checks and queued read checks
`timescale 1ns/1ns
module tb_pgrr_top;
  import pgrr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic cpuSleep = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [NUM_PERIPH-1:0] periphClkEn, periphRst, periphReady;
  logic [NUM_PERIPH-1:0][15:0] activity;
  logic [15:0] snap [NUM_PERIPH];
  logic [31:0] expQ [$];
  logic rdSeen = 1'b0;
  int mismatches = 0;
  int cmpCount = 0;
  int cycles = 0;
  logic [7:0] mask, sm, bitK, gated;
  int k, j;

  always #25 ref_clk = ~ref_clk;

  pgrr_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .cpuSleep(cpuSleep),
    .periphClkEn(periphClkEn), .periphRst(periphRst), .periphReady(periphReady));
  pgrr_periph_model model (.ref_clk(ref_clk), .rst_n(rst_n), .periphClkEn(periphClkEn),
    .periphRst(periphRst), .activity(activity));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= {24'h000000, d};
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({24'h000000, e});
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // read data monitor: oldest queued note against the answer cycle
  always @(posedge ref_clk) rdSeen <= regRdStb;
  always @(negedge ref_clk) begin
    if (rdSeen) begin
      chk("regRdData", expQ.pop_front(), regRdData);
    end
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      giveVerdict();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(52));
    k = $urandom_range(7, 0);
    j = (k + 1) % 8;
    bitK = 8'h01 << k;
    mask = 8'($urandom) | bitK | (8'h01 << j) | 8'h01; // slot 0 always enabled
    sm = 8'($urandom) & ~bitK;
    gated = mask & ~sm;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    edges(0);
    chk("periphReady", 8'h00, periphReady);
    chk("periphClkEn", 8'h00, periphClkEn);
    @(posedge ref_clk);
    rdReg(ADDR_RUN_EN, 8'h00);
    rdReg(ADDR_SLEEP_EN, 8'hFF);
    rdReg(ADDR_GATING, 8'h00);
    rdReg(ADDR_READY, 8'h00);
    rdReg(8'h18, 8'h00);
    rdReg(ADDR_RST_BUSY, 8'h00);
    $display("test reset values done");
    wrReg(ADDR_RUN_EN, mask);
    edges(4);
    chk("periphReady early", 8'h00, periphReady);
    chk("periphClkEn", mask, periphClkEn);
    edges(1);
    chk("periphReady", mask, periphReady);
    @(posedge ref_clk);
    rdReg(ADDR_READY, mask);
    rdReg(ADDR_RUN_EN, mask);
    $display("test enable and ready done");
    snap[j] = activity[j];
    wrReg(ADDR_SOFT_RST, bitK);
    for (int n = 0; n < 6; n++) begin
      edges(n == 0 ? 0 : 1);
      chk("periphRst", (n >= 1 && n <= 4) ? bitK : 8'h00, periphRst);
      if (n == 2) chk("periphReady in reset", mask & ~bitK, periphReady);
      if (n == 4) chk("reset slot state", 16'h0000, activity[k]);
    end
    chk("other slot running", 1, activity[j] > snap[j]);
    edges(4);
    chk("periphReady settling", mask & ~bitK, periphReady);
    edges(1);
    chk("periphReady after reset", mask, periphReady);
    @(posedge ref_clk);
    rdReg(ADDR_SOFT_RST, 8'h00);
    $display("test soft reset done");
    wrReg(ADDR_SLEEP_EN, sm);
    @(posedge ref_clk);
    wrReg(ADDR_GATING, 8'h01);
    cpuSleep <= 1'b1;
    edges(2);
    chk("periphClkEn asleep", mask & sm, periphClkEn);
    for (int i = 0; i < NUM_PERIPH; i++) snap[i] = activity[i];
    edges(10);
    chk("periphReady asleep", mask, periphReady);
    for (int i = 0; i < NUM_PERIPH; i++) begin
      if (gated[i]) chk("gated slot state", snap[i], activity[i]);
    end
    @(posedge ref_clk);
    cpuSleep <= 1'b0;
    edges(1);
    chk("periphClkEn awake", mask, periphClkEn);
    edges(1);
    for (int i = 0; i < NUM_PERIPH; i++) begin
      if (gated[i]) chk("slot resumes", snap[i] + 16'h0001, activity[i]);
    end
    $display("test sleep gating done");
    @(posedge ref_clk);
    wrReg(ADDR_GATING, 8'h00);
    cpuSleep <= 1'b1;
    edges(3);
    chk("periphClkEn option off", mask, periphClkEn);
    @(posedge ref_clk);
    rdReg(ADDR_SLEEP_EN, sm);
    cpuSleep <= 1'b0;
    wrReg(ADDR_RUN_EN, 8'h00);
    edges(2);
    chk("periphReady disabled", 8'h00, periphReady);
    chk("periphClkEn disabled", 8'h00, periphClkEn);
    $display("test option off and disable done");
    @(posedge ref_clk);
    wrReg(ADDR_SOFT_RST, bitK);
    @(posedge ref_clk);
    rdReg(ADDR_RST_BUSY, bitK);
    $display("test reset busy done");
    edges(2);
    giveVerdict();
  end
endmodule
